/* File: include/aaops_map.svh */
// Constants for the add and logic datapath: operation codes, flag positions, reset values
`ifndef AAOPS_MAP_SVH
`define AAOPS_MAP_SVH
`define AAOPS_OP_NONE      4'h0
`define AAOPS_OP_ADC_A     4'h1
`define AAOPS_OP_ADC_M     4'h2
`define AAOPS_OP_ADD_A     4'h3
`define AAOPS_OP_ADD_X     4'h4
`define AAOPS_OP_ADD_M     4'h5
`define AAOPS_OP_AND_A     4'h6
`define AAOPS_OP_AND_X     4'h7
`define AAOPS_OP_AND_M     4'h8
`define AAOPS_FLAG_OUTFLOW 0
`define AAOPS_FLAG_NIBBLE  1
`define AAOPS_FLAG_NULL    2
`define AAOPS_FLAG_SIGNED  3
`define AAOPS_WORK_RESET   8'h00
`define AAOPS_FLAGS_RESET  4'h0
`endif

/* File: include/aaops_pkg.sv */
// Types shared by the add and logic datapath
package aaops_pkg;
	typedef logic [3:0] aaops_op_type;
	typedef struct packed {
		logic signed_range_flag;
		logic null_flag;
		logic nibble_carry_flag;
		logic outflow_flag;
	} aaops_flags_type;
	typedef struct packed {
		logic       valid;
		logic [3:0] op;
		logic [7:0] mem_byte;
		logic [7:0] imm_byte;
	} aaops_req_type;
endpackage

/* File: hw/aaops_adder.sv */
// Eight-bit adder that reports the nibble, outflow and signed range carries
`timescale 1ns/1ps
module aaops_adder #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] a_i,
	input  wire logic [WIDTH-1:0] b_i,
	input  wire logic             cin_i,
	output logic      [WIDTH-1:0] sum_o,
	output logic                  nibble_o,
	output logic                  outflow_o,
	output logic                  signed_o
);
	logic [4:0]     low_sum;
	logic [WIDTH:0] full_sum;
	// Nibble carry computed on its own low slice, carry out of bit 3
	always_comb begin
		low_sum   = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
		full_sum  = {1'b0, a_i} + {1'b0, b_i} + {{WIDTH{1'b0}}, cin_i};
		sum_o     = full_sum[WIDTH-1:0];
		nibble_o  = low_sum[4];
		outflow_o = full_sum[WIDTH];
		// Overflow when both operands agree in sign and result disagrees
		signed_o  = (a_i[WIDTH-1] == b_i[WIDTH-1]) && (sum_o[WIDTH-1] != a_i[WIDTH-1]);
	end
endmodule

/* File: hw/aaops_core.sv */
// Add and AND datapath: work register, status flags and memory write-back
`timescale 1ns/1ps
`include "aaops_map.svh"
module aaops_core
	import aaops_pkg::*;
(
	input  wire logic          clk_sys_i,
	input  wire logic          reset_i,
	input  wire aaops_req_type req_i,
	output logic [7:0]         work_register_o,
	output aaops_flags_type    flags_o,
	output logic               mem_we_o,
	output logic [7:0]         mem_wdata_o,
	output logic               done_o
);
	// Idle between ops, busy while a result is on the outputs
	typedef enum logic [1:0] {
		AAOPS_ST_IDLE = 2'b01,
		AAOPS_ST_BUSY = 2'b10
	} aaops_state_type;

	aaops_state_type state_r, state_nxt;
	logic [7:0]      work_r, work_nxt;
	aaops_flags_type flags_r, flags_nxt;
	logic            we_r, we_nxt;
	logic [7:0]      wdata_r, wdata_nxt;
	logic            done_r, done_nxt;
	logic [7:0]      add_b;
	logic            add_cin;
	logic [7:0]      add_sum;
	logic            add_nib, add_out, add_sgn;
	logic [7:0]      and_res;

	// Operand comes from the instruction word, not from memory
	function automatic logic op_takes_imm(input aaops_op_type op);
		return (op == `AAOPS_OP_ADD_X) || (op == `AAOPS_OP_AND_X);
	endfunction

	// Carry-adds are the only ops that consume the stored outflow bit
	function automatic logic op_uses_carry(input aaops_op_type op);
		return (op == `AAOPS_OP_ADC_A) || (op == `AAOPS_OP_ADC_M);
	endfunction

	// Adder-based ops; these rewrite all four flags
	function automatic logic op_is_arith(input aaops_op_type op);
		return op inside {`AAOPS_OP_ADC_A, `AAOPS_OP_ADC_M, `AAOPS_OP_ADD_A, `AAOPS_OP_ADD_X, `AAOPS_OP_ADD_M};
	endfunction

	// Bitwise ops; only the null flag follows them
	function automatic logic op_is_logic(input aaops_op_type op);
		return op inside {`AAOPS_OP_AND_A, `AAOPS_OP_AND_X, `AAOPS_OP_AND_M};
	endfunction

	// Select adder operand and carry-in per operation
	always_comb begin
		add_b   = op_takes_imm(req_i.op) ? req_i.imm_byte : req_i.mem_byte;
		add_cin = 1'b0;
		if (op_uses_carry(req_i.op)) begin
			add_cin = flags_r.outflow_flag;
		end
		and_res = work_r & (op_takes_imm(req_i.op) ? req_i.imm_byte : req_i.mem_byte);
	end

	aaops_adder #(
		.WIDTH(8)
	) u_adder (
		.a_i      (work_r),
		.b_i      (add_b),
		.cin_i    (add_cin),
		.sum_o    (add_sum),
		.nibble_o (add_nib),
		.outflow_o(add_out),
		.signed_o (add_sgn)
	);

	// Next state; one operation per valid cycle, result registered once
	always_comb begin
		state_nxt = AAOPS_ST_IDLE;
		work_nxt  = work_r;
		flags_nxt = flags_r;
		we_nxt    = 1'b0;
		wdata_nxt = wdata_r;
		done_nxt  = 1'b0;
		if (req_i.valid) begin
			state_nxt = AAOPS_ST_BUSY;
			done_nxt  = 1'b1;
			unique case (req_i.op)
				`AAOPS_OP_ADC_A, `AAOPS_OP_ADD_A, `AAOPS_OP_ADD_X: begin
					work_nxt = add_sum;
				end
				`AAOPS_OP_ADC_M, `AAOPS_OP_ADD_M: begin
					we_nxt    = 1'b1;
					wdata_nxt = add_sum;
				end
				`AAOPS_OP_AND_A, `AAOPS_OP_AND_X: begin
					work_nxt = and_res;
				end
				`AAOPS_OP_AND_M: begin
					we_nxt    = 1'b1;
					wdata_nxt = and_res;
				end
				default: begin
					done_nxt = 1'b0; // Unknown codes only move the state to busy
				end
			endcase
			// Arithmetic ops update all four flags
			if (op_is_arith(req_i.op)) begin
				flags_nxt.outflow_flag      = add_out;
				flags_nxt.nibble_carry_flag = add_nib;
				flags_nxt.signed_range_flag = add_sgn;
				flags_nxt.null_flag         = (add_sum == 8'h00);
			end
			// Logic ops touch the null flag alone
			if (op_is_logic(req_i.op)) begin
				flags_nxt.null_flag = (and_res == 8'h00);
			end
		end
	end

	// State registers
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_r <= AAOPS_ST_IDLE;
			work_r  <= `AAOPS_WORK_RESET;
			flags_r <= `AAOPS_FLAGS_RESET;
			we_r    <= 1'b0;
			wdata_r <= 8'h00;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			work_r  <= work_nxt;
			flags_r <= flags_nxt;
			we_r    <= we_nxt;
			wdata_r <= wdata_nxt;
			done_r  <= done_nxt;
		end
	end

	assign work_register_o = work_r;
	assign flags_o         = flags_r;
	assign mem_we_o        = we_r;
	assign mem_wdata_o     = wdata_r;
	assign done_o          = done_r;

	// Checks
	AST_ADC_A_SUM: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADC_A |=> work_r == 8'($past(work_r) + $past(req_i.mem_byte)
		+ {7'h00, $past(flags_r.outflow_flag)})) else $error("carry add to work wrong");
	AST_ADC_M_WB: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADC_M |=> mem_we_o && mem_wdata_o == 8'($past(work_r)
		+ $past(req_i.mem_byte) + {7'h00, $past(flags_r.outflow_flag)})) else $error("carry add to memory wrong");
	AST_ADD_A_SUM: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_A |=> work_r == 8'($past(work_r) + $past(req_i.mem_byte)))
		else $error("plain add wrong");
	AST_ADD_X_SUM: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_X |=> work_r == 8'($past(work_r) + $past(req_i.imm_byte)))
		else $error("immediate add wrong");
	AST_ADD_M_KEEP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_M |=> $stable(work_r) && mem_we_o)
		else $error("add to memory changed work register");
	AST_AND_A_FLAGS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_AND_A |=> $stable(flags_r.outflow_flag)
		&& $stable(flags_r.nibble_carry_flag) && $stable(flags_r.signed_range_flag))
		else $error("and changed arithmetic flags");
	AST_AND_X_NULL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_AND_X |=> flags_r.null_flag == (work_r == 8'h00))
		else $error("and immediate null flag wrong");
	AST_AND_M_WB: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_AND_M |=> mem_we_o && $stable(work_r)
		&& mem_wdata_o == ($past(work_r) & $past(req_i.mem_byte))) else $error("and to memory wrong");
	AST_NULL_FLAG: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_M |=> flags_r.null_flag == (mem_wdata_o == 8'h00)
		##1 !mem_we_o || $past(req_i.valid)) else $error("null flag wrong");
	AST_OUTFLOW: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_A |=> flags_r.outflow_flag
		== ((9'($past(work_r)) + 9'($past(req_i.mem_byte))) > 9'h0FF)) else $error("outflow flag wrong");

	// Flag and result checks per operation, against the sums themselves
	AST_ADC_A_NIB: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADC_A |=> flags_r.nibble_carry_flag
		== ((5'($past(work_r[3:0])) + 5'($past(req_i.mem_byte[3:0])) + 5'($past(flags_r.outflow_flag))) > 5'h0F))
		else $error("carry add nibble flag wrong");
	AST_ADC_A_NULL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADC_A |=> flags_r.null_flag == (work_r == 8'h00))
		else $error("carry add null flag wrong");
	AST_ADC_M_OUT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADC_M |=> flags_r.outflow_flag
		== ((9'($past(work_r)) + 9'($past(req_i.mem_byte)) + 9'($past(flags_r.outflow_flag))) > 9'h0FF))
		else $error("carry add to memory outflow flag wrong");
	AST_ADC_M_KEEP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADC_M |=> $stable(work_r))
		else $error("carry add to memory changed work register");
	AST_ADD_A_NULL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_A |=> flags_r.null_flag == (work_r == 8'h00))
		else $error("plain add null flag wrong");
	AST_ADD_X_OUT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_X |=> flags_r.outflow_flag
		== ((9'($past(work_r)) + 9'($past(req_i.imm_byte))) > 9'h0FF))
		else $error("immediate add outflow flag wrong");
	AST_ADD_M_WB: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_M |=> mem_wdata_o == 8'($past(work_r) + $past(req_i.mem_byte)))
		else $error("add to memory sum wrong");
	AST_ADD_M_OUT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_M |=> flags_r.outflow_flag
		== ((9'($past(work_r)) + 9'($past(req_i.mem_byte))) > 9'h0FF))
		else $error("add to memory outflow flag wrong");
	AST_AND_A_RES: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_AND_A |=> work_r == ($past(work_r) & $past(req_i.mem_byte))
		&& flags_r.null_flag == (work_r == 8'h00))
		else $error("and from memory result wrong");
	AST_AND_X_RES: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_AND_X |=> work_r == ($past(work_r) & $past(req_i.imm_byte))
		&& $stable(flags_r.outflow_flag) && $stable(flags_r.signed_range_flag))
		else $error("and immediate result wrong");
	AST_AND_M_FLAGS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_AND_M |=> $stable(flags_r.outflow_flag)
		&& $stable(flags_r.nibble_carry_flag) && flags_r.null_flag == (mem_wdata_o == 8'h00))
		else $error("and to memory flags wrong");
	AST_SIGNED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_X |=> flags_r.signed_range_flag
		== (($past(work_r[7]) == $past(req_i.imm_byte[7])) && (work_r[7] != $past(work_r[7]))))
		else $error("signed range flag wrong");
	AST_NIBBLE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.valid && req_i.op == `AAOPS_OP_ADD_M |=> flags_r.nibble_carry_flag
		== ((5'($past(work_r[3:0])) + 5'($past(req_i.mem_byte[3:0]))) > 5'h0F))
		else $error("nibble carry flag wrong");

	// Main scenarios worth seeing at least once
	COV_ADC_CARRY: cover property (@(posedge clk_sys_i) req_i.valid && req_i.op == `AAOPS_OP_ADC_A
		&& flags_r.outflow_flag);
	COV_ADD_OVF: cover property (@(posedge clk_sys_i) req_i.valid && req_i.op == `AAOPS_OP_ADD_X ##1 flags_r.signed_range_flag);
	COV_AND_ZERO: cover property (@(posedge clk_sys_i) req_i.valid && req_i.op == `AAOPS_OP_AND_M ##1 flags_r.null_flag);
	COV_BACK2BACK: cover property (@(posedge clk_sys_i) state_r == AAOPS_ST_BUSY && req_i.valid);
endmodule

/* File: verification/aaops_mem_model.sv */
// Far-side model: data memory with write-back and bypass
`timescale 1ns/1ps
module aaops_mem_model (
	input  wire logic       clk_sys_i,
	input  wire logic       valid_i,
	input  wire logic [3:0] addr_i,
	input  wire logic       mem_we_i,
	input  wire logic [7:0] mem_wdata_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem [16];
	logic [3:0] wr_addr_r = 4'h0;
	// Write lands one cycle after the op is taken
	always @(posedge clk_sys_i) begin
		if (valid_i) wr_addr_r <= addr_i;
		if (mem_we_i) mem[wr_addr_r] <= mem_wdata_i;
	end
	// Bypass, else back-to-back ops would read a stale byte
	assign rdata_o = (mem_we_i && wr_addr_r == addr_i) ? mem_wdata_i : mem[addr_i];
	initial for (int i = 0; i < 16; i++) mem[i] = 8'(i * 17);
endmodule

/* File: verification/add_and_alu_ops_tb.sv */
// Self-checking bench for the add and AND datapath
`timescale 1ns/1ps
`include "aaops_map.svh"
module add_and_alu_ops_tb;
	import aaops_pkg::*;
	logic            clk_sys_i = 1'b0;
	logic            reset_i   = 1'b1;
	logic            v         = 1'b0;
	logic [3:0]      op_b      = 4'h0;
	logic [7:0]      imm_b     = 8'h00;
	logic [3:0]      addr      = 4'h0;
	aaops_req_type   req_i;
	logic [7:0]      work_register_o, mem_wdata_o, rdata, ew, emem [16];
	aaops_flags_type flags_o, ef;
	logic            mem_we_o, done_o;
	int              fails     = 0;
	int              cmp_count = 0;
	initial forever #20 clk_sys_i = ~clk_sys_i;
	// Memory byte comes straight from the far-side model
	always_comb req_i = {v, op_b, rdata, imm_b};
	aaops_core uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(req_i), .work_register_o(work_register_o),
		.flags_o(flags_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .done_o(done_o));
	aaops_mem_model far (.clk_sys_i(clk_sys_i), .valid_i(v), .addr_i(addr), .mem_we_i(mem_we_o),
		.mem_wdata_i(mem_wdata_o), .rdata_o(rdata));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// One op, checked one cycle later against the bench's own model
	task automatic run_op(input logic [3:0] op, input logic [3:0] a, input logic [7:0] imm);
		logic [7:0] b;
		logic [8:0] s;
		logic       cin, legal, wr;
		b = (op == 4'h4 || op == 4'h7) ? imm : emem[a];
		cin = (op == 4'h1 || op == 4'h2) ? ef.outflow_flag : 1'b0;
		legal = op >= 4'h1 && op <= 4'h8;
		wr = legal && (op == 4'h2 || op == 4'h5 || op == 4'h8);
		v = 1'b1;
		op_b = op;
		imm_b = imm;
		addr = a;
		if (legal) begin
			s = (op >= 4'h6) ? {1'b0, ew & b} : ew + b + cin;
			if (op < 4'h6) begin
				ef.nibble_carry_flag = (5'(ew[3:0]) + b[3:0] + cin) > 5'h0F;
				ef.outflow_flag = s[8];
				ef.signed_range_flag = ew[7] == b[7] && s[7] != ew[7];
			end
			ef.null_flag = s[7:0] == 8'h00;
			if (wr) emem[a] = s[7:0];
			else ew = s[7:0];
		end
		@(posedge clk_sys_i);
		#1;
		chk("done", {7'h0, legal}, {7'h0, done_o});
		chk("we", {7'h0, wr}, {7'h0, mem_we_o});
		if (wr) chk("wdata", emem[a], mem_wdata_o);
		chk("work", ew, work_register_o);
		chk("flags", {4'h0, ef}, {4'h0, flags_o});
	endtask
	// Drop the request; both pulses must be gone
	task automatic idle();
		v = 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk("done low", 8'h00, {7'h0, done_o});
		chk("we low", 8'h00, {7'h0, mem_we_o});
	endtask
	task automatic s_reset();
		chk("work", `AAOPS_WORK_RESET, work_register_o);
		chk("flags", {4'h0, `AAOPS_FLAGS_RESET}, {4'h0, flags_o});
		chk("done", 8'h00, {7'h0, done_o | mem_we_o});
		chk("wdata", 8'h00, mem_wdata_o);
	endtask
	task automatic s_add_imm();
		run_op(`AAOPS_OP_ADD_X, 4'h0, 8'h80);
		run_op(`AAOPS_OP_ADD_X, 4'h0, 8'h80);
		idle();
	endtask
	task automatic s_carry();
		run_op(`AAOPS_OP_ADC_A, 4'h1, 8'h00);
		run_op(`AAOPS_OP_ADC_M, 4'h2, 8'h00);
		run_op(`AAOPS_OP_ADC_M, 4'h2, 8'h00);
		idle();
	endtask
	task automatic s_plain();
		run_op(`AAOPS_OP_ADD_X, 4'h0, 8'hF0);
		run_op(`AAOPS_OP_ADD_A, 4'h3, 8'h00);
		run_op(`AAOPS_OP_ADD_M, 4'hF, 8'h00);
		idle();
	endtask
	task automatic s_and();
		run_op(`AAOPS_OP_AND_A, 4'hF, 8'h00);
		run_op(`AAOPS_OP_AND_M, 4'h4, 8'h00);
		run_op(`AAOPS_OP_AND_X, 4'h0, 8'h00);
		idle();
	endtask
	// Unused codes must leave everything alone
	task automatic s_refused();
		run_op(`AAOPS_OP_NONE, 4'h5, 8'hFF);
		for (int c = 9; c < 16; c++) run_op(4'(c), 4'h5, 8'hFF);
		idle();
	endtask
	// Carry into a memory write, then immediate adds that set the carry again, then a plain memory add that must ignore it
	task automatic s_carry_mem();
		run_op(`AAOPS_OP_ADC_M, 4'h6, 8'h00);
		run_op(`AAOPS_OP_ADD_X, 4'h0, 8'hFF);
		run_op(`AAOPS_OP_ADD_X, 4'h0, 8'h01);
		run_op(`AAOPS_OP_ADD_M, 4'h6, 8'h00);
		idle();
	endtask
	// Reset mid-run with work and write data nonzero, then an op at once
	task automatic s_mid_reset();
		run_op(`AAOPS_OP_ADD_X, 4'h0, 8'hC3);
		idle();
		reset_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		ew = `AAOPS_WORK_RESET;
		ef = `AAOPS_FLAGS_RESET;
		s_reset();
		reset_i = 1'b0;
		run_op(`AAOPS_OP_ADC_A, 4'h7, 8'h00);
		idle();
	endtask
	// Main sequence
	initial begin
		ew = `AAOPS_WORK_RESET;
		ef = `AAOPS_FLAGS_RESET;
		for (int i = 0; i < 16; i++) emem[i] = 8'(i * 17);
		repeat (12) @(posedge clk_sys_i);
		#1;
		s_reset();
		reset_i = 1'b0;
		s_add_imm();
		s_carry();
		s_plain();
		s_and();
		s_refused();
		s_carry_mem();
		s_mid_reset();
		wrap_up();
	end
endmodule
